// *** rtl/sgtp_top.sv ***
// design: sequencer gpio port, test-set outputs and apb register file
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module sgtp_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        preset_req,
  input  wire logic        autostart_titled,
  input  wire logic [4:0]  par_in,
  output logic [7:0]       par_out,
  output logic [2:0]       fixture_code,
  output logic             fixture_valid_n,
  output logic             fwd_dir,
  input  wire logic        sweep_delay,
  input  wire logic        sweep_request,
  output logic             sweep_start,
  input  wire logic        end_of_sweep,
  output logic             seq_out,
  output logic             tset_seq_out,
  input  wire logic        limit_fail,
  output logic             tset_limit_out
);
  // register state
  logic [7:0]  ctrl_reg;      // control register
  logic [7:0]  par_reg;       // parallel output byte
  logic [2:0]  fwd_code_reg;  // forward_fixture_code
  logic [2:0]  rev_code_reg;  // reverse_fixture_code
  logic [2:0]  code_reg;      // code driven on the lines
  logic        strobe_n_reg;  // valid strobe, low while stable
  logic        dir_reg;       // registered direction line
  logic        seq_reg;       // sequencing output flop
  logic [4:0]  pulse_reg;     // end-of-sweep pulse counter
  logic        limit_reg;     // limit copy flop
  logic        pend_reg;      // sweep waiting to start
  logic        start_reg;     // sweep start pulse
  logic [15:0] loop_reg;      // loop counter
  logic [11:0] size_reg;      // accumulated sequence bytes
  logic [31:0] rdata_reg;     // read data captured in setup
  logic        por_reg;       // power-up check already done
  sgtp_pkg::sgtp_state_e state_reg; // sequencer state
  logic [2:0]  slot_reg;      // running slot
  logic [7:0]  pc_reg;        // command index in slot
  logic        ret_ok_reg;    // a return point is stored
  logic [2:0]  ret_slot_reg;  // caller slot
  logic [7:0]  ret_pc_reg;    // caller resume index

  // bus decode helpers
  logic        wr_en;         // write accepted this edge
  logic        setup;         // setup phase of a transfer
  logic        mapped;        // address hits a register
  logic        gpio_mode;     // general purpose mode active
  logic [1:0]  som;           // sequencing output mode
  logic [2:0]  in_sel;        // input_bit_select
  logic        in_bit;        // selected input level
  logic [2:0]  cmd_op;        // opcode of a sequencer write
  logic [2:0]  cmd_dest;      // destination slot of a write
  logic        dest_ok;       // destination is a real slot
  logic        take_jump;     // current write transfers control

  // five-digit decimal rendering of the loop counter
  function automatic logic [19:0] sgtp_to_bcd(input logic [15:0] bin);
    logic [19:0] bcd;
    bcd = 20'h00000;
    for (int i = 15; i >= 0; i--)
    begin
      for (int d = 0; d < 5; d++)
      begin
        if (bcd[d*4 +: 4] > 4'h4)
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
      end
      bcd = {bcd[18:0], bin[i]};
    end
    return bcd;
  endfunction

  // one-hot mask for an output bit index
  function automatic logic [7:0] sgtp_bit(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction

  assign setup     = psel & ~penable;
  assign wr_en     = psel & penable & pwrite;
  assign mapped    = (paddr <= sgtp_pkg::ADDR_SIZE) &&
                     (paddr[1:0] == 2'h0);
  assign gpio_mode = ctrl_reg[sgtp_pkg::CTRL_GPIO];
  assign som       = ctrl_reg[sgtp_pkg::CTRL_SOM_LO +: 2];
  assign in_sel    = ctrl_reg[sgtp_pkg::CTRL_SEL_LO +: 3];
  // selectors past the fifth input read low
  assign in_bit    = (in_sel <= sgtp_pkg::IN_BITS_MAX) ?
                     par_in[in_sel] : 1'b0;
  assign cmd_op    = pwdata[2:0];
  assign cmd_dest  = pwdata[sgtp_pkg::SEQ_DEST_LO +: 3];
  assign dest_ok   = (cmd_dest >= sgtp_pkg::SLOT_FIRST) &&
                     (cmd_dest <= sgtp_pkg::SLOT_LAST);
  // which writes move control to the destination slot
  always_comb
  begin
    take_jump = 1'b0;
    case (cmd_op)
      sgtp_pkg::OP_JUMP:   take_jump = 1'b1;
      sgtp_pkg::OP_CALL:   take_jump = 1'b1;
      sgtp_pkg::OP_JMP_HI: take_jump = in_bit;
      sgtp_pkg::OP_JMP_LO: take_jump = ~in_bit;
      default:             take_jump = 1'b0;
    endcase
  end

  // apb answers at once; unmapped addresses give an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rdata_reg;

  // read data captured during the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_reg <= 32'h00000000;
    else if (setup && !pwrite)
    begin
      if (paddr == sgtp_pkg::ADDR_CTRL)
        rdata_reg <= {24'h000000, ctrl_reg};
      else if (paddr == sgtp_pkg::ADDR_PAROUT)
        rdata_reg <= {24'h000000, par_reg};
      else if (paddr == sgtp_pkg::ADDR_FIXTURE)
        rdata_reg <= {25'h0000000, rev_code_reg, 1'b0, fwd_code_reg};
      else if (paddr == sgtp_pkg::ADDR_SEQSTAT)
        rdata_reg <= {10'h000, par_in, pc_reg, 1'b0, ret_slot_reg,
                      ret_ok_reg, slot_reg, state_reg == sgtp_pkg::SGTP_RUN};
      else if (paddr == sgtp_pkg::ADDR_LOOP)
        rdata_reg <= {16'h0000, loop_reg};
      else if (paddr == sgtp_pkg::ADDR_LOOPDEC)
        rdata_reg <= {12'h000, sgtp_to_bcd(loop_reg)};
      else if (paddr == sgtp_pkg::ADDR_SIZE)
        rdata_reg <= {20'h00000, size_reg};
      else
        rdata_reg <= 32'h00000000;
    end
  end

  // control register; preset returns it to defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= 8'h00;
    else if (preset_req)
      ctrl_reg <= 8'h00;
    else if (wr_en && paddr == sgtp_pkg::ADDR_CTRL)
      ctrl_reg <= pwdata[7:0];
  end

  // parallel output byte and bit commands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      par_reg <= 8'h00;
    else if (preset_req)
      par_reg <= 8'h00;
    else if (wr_en && paddr == sgtp_pkg::ADDR_PAROUT)
      par_reg <= pwdata[7:0];
    else if (wr_en && paddr == sgtp_pkg::ADDR_BITCMD && gpio_mode)
    begin
      if (pwdata[sgtp_pkg::BIT_SET])
        par_reg <= par_reg | sgtp_bit(pwdata[2:0]);
      else if (pwdata[sgtp_pkg::BIT_CLR])
        par_reg <= par_reg & ~sgtp_bit(pwdata[2:0]);
    end
  end
  assign par_out = par_reg;

  // forward and reverse fixture codes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwd_code_reg <= 3'h0;
      rev_code_reg <= 3'h0;
    end
    else if (wr_en && paddr == sgtp_pkg::ADDR_FIXTURE)
    begin
      fwd_code_reg <= pwdata[2:0];
      rev_code_reg <= pwdata[sgtp_pkg::FIX_REV_LO +: 3];
    end
  end

  // code lines follow direction; strobe high for one cycle on a change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      code_reg     <= 3'h0;
      dir_reg      <= 1'b0;
      strobe_n_reg <= 1'b1;
    end
    else
    begin
      dir_reg  <= ctrl_reg[sgtp_pkg::CTRL_FWD];
      code_reg <= ctrl_reg[sgtp_pkg::CTRL_FWD] ?
                  fwd_code_reg : rev_code_reg;
      // low only when the lines did not move this edge
      strobe_n_reg <= (code_reg != (ctrl_reg[sgtp_pkg::CTRL_FWD] ?
                       fwd_code_reg : rev_code_reg));
    end
  end
  assign fixture_code    = code_reg;
  assign fixture_valid_n = strobe_n_reg;
  assign fwd_dir         = dir_reg;

  // sweep start held off while the test set asks for delay
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_reg  <= 1'b0;
      start_reg <= 1'b0;
    end
    else
    begin
      start_reg <= pend_reg & ~sweep_delay;
      if (pend_reg && !sweep_delay)
        pend_reg <= sweep_request;
      else if (sweep_request)
        pend_reg <= 1'b1;
    end
  end
  assign sweep_start = start_reg;

  // sequencing output and its connector copies
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_reg   <= 1'b0;
      pulse_reg <= 5'h00;
      limit_reg <= 1'b0;
    end
    else
    begin
      limit_reg <= limit_fail;
      if (end_of_sweep)
        pulse_reg <= sgtp_pkg::PULSE_CNT;
      else if (pulse_reg != 5'h00)
        pulse_reg <= pulse_reg - 5'h01;
      case (som)
        sgtp_pkg::SOM_STATIC_HIGH: seq_reg <= 1'b1;
        sgtp_pkg::SOM_PULSE_HIGH:  seq_reg <= end_of_sweep ||
                                              pulse_reg > 5'h01;
        sgtp_pkg::SOM_PULSE_LOW:   seq_reg <= !(end_of_sweep ||
                                              pulse_reg > 5'h01);
        default:                   seq_reg <= 1'b0;
      endcase
    end
  end
  assign seq_out        = seq_reg;
  assign tset_seq_out   = seq_reg;
  assign tset_limit_out = limit_reg;

  // loop counter and size accounting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_reg <= 16'h0000;
      size_reg <= 12'h000;
    end
    else
    begin
      if (wr_en && paddr == sgtp_pkg::ADDR_LOOP)
        loop_reg <= pwdata[15:0];
      if (wr_en && paddr == sgtp_pkg::ADDR_SIZE)
      begin
        if (pwdata[sgtp_pkg::SIZE_CLEAR])
          size_reg <= 12'h000;
        else if (pwdata[1:0] == sgtp_pkg::KIND_TYPICAL)
          size_reg <= size_reg + sgtp_pkg::COST_TYPICAL;
        else if (pwdata[1:0] == sgtp_pkg::KIND_TITLE)
          size_reg <= size_reg + sgtp_pkg::COST_TITLE;
        else if (pwdata[1:0] == sgtp_pkg::KIND_ENTRY)
          size_reg <= size_reg +
                      {8'h00, pwdata[sgtp_pkg::SIZE_CNT_LO +: 4]};
      end
    end
  end

  // sequencer: autostart, jumps, call and return
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_reg      <= 1'b0;
      state_reg    <= sgtp_pkg::SGTP_IDLE;
      slot_reg     <= 3'h0;
      pc_reg       <= 8'h00;
      ret_ok_reg   <= 1'b0;
      ret_slot_reg <= 3'h0;
      ret_pc_reg   <= 8'h00;
    end
    else if (!por_reg)
    begin
      // only the first edge after power-up may autostart
      por_reg <= 1'b1;
      if (autostart_titled)
      begin
        state_reg <= sgtp_pkg::SGTP_RUN;
        slot_reg  <= sgtp_pkg::SLOT_AUTO;
        pc_reg    <= 8'h00;
      end
    end
    else if (preset_req)
    begin
      state_reg  <= sgtp_pkg::SGTP_IDLE;
      ret_ok_reg <= 1'b0;
    end
    else if (wr_en && paddr == sgtp_pkg::ADDR_SEQCMD)
    begin
      case (state_reg)
        sgtp_pkg::SGTP_IDLE:
        begin
          // a jump or call from idle starts the named slot
          if (take_jump && dest_ok)
          begin
            state_reg <= sgtp_pkg::SGTP_RUN;
            slot_reg  <= cmd_dest;
            pc_reg    <= 8'h00;
          end
        end
        sgtp_pkg::SGTP_RUN:
        begin
          if (cmd_op == sgtp_pkg::OP_STOP)
            state_reg <= sgtp_pkg::SGTP_IDLE;
          else if (cmd_op == sgtp_pkg::OP_RETURN)
          begin
            if (ret_ok_reg)
            begin
              slot_reg   <= ret_slot_reg;
              pc_reg     <= ret_pc_reg;
              ret_ok_reg <= 1'b0;
            end
            else
              state_reg <= sgtp_pkg::SGTP_IDLE;
          end
          else if (take_jump && dest_ok)
          begin
            if (cmd_op == sgtp_pkg::OP_CALL)
            begin
              ret_ok_reg   <= 1'b1;
              ret_slot_reg <= slot_reg;
              ret_pc_reg   <= pc_reg + 8'h01;
            end
            slot_reg <= cmd_dest;
            pc_reg   <= 8'h00;
          end
          else
            pc_reg <= pc_reg + 8'h01;
        end
        default:
          state_reg <= sgtp_pkg::SGTP_IDLE;
      endcase
    end
  end

  // checks beside the logic
  a_byte_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_en && paddr == sgtp_pkg::ADDR_PAROUT && !preset_req
    |=> par_out == $past(pwdata[7:0]))
    else $error("byte write not driven");
  a_bit_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_en && paddr == sgtp_pkg::ADDR_BITCMD && gpio_mode && !preset_req
    && pwdata[sgtp_pkg::BIT_SET]
    |=> par_out == ($past(par_out) | sgtp_bit($past(pwdata[2:0]))))
    else $error("bit set wrong");
  a_bit_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_en && paddr == sgtp_pkg::ADDR_BITCMD && gpio_mode && !preset_req
    && !pwdata[sgtp_pkg::BIT_SET] && pwdata[sgtp_pkg::BIT_CLR]
    |=> par_out == ($past(par_out) & ~sgtp_bit($past(pwdata[2:0]))))
    else $error("bit clear wrong");
  a_copy_mode: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_en && paddr == sgtp_pkg::ADDR_BITCMD && !gpio_mode && !preset_req
    |=> $stable(par_out))
    else $error("bit command acted in copy mode");
  // codes must stand two samples, else a code write races the lines
  a_code_select: assert property (@(posedge pclk)
    disable iff (!presetn)
    ($stable(ctrl_reg) && $stable(fwd_code_reg) && $stable(rev_code_reg))
    ##1 ($stable(ctrl_reg) && $stable(fwd_code_reg)
    && $stable(rev_code_reg))
    |-> fixture_code == (fwd_dir ? fwd_code_reg : rev_code_reg))
    else $error("fixture code not matching direction");
  a_strobe_valid: assert property (@(posedge pclk)
    disable iff (!presetn)
    !fixture_valid_n |-> $stable(fixture_code))
    else $error("strobe low while code moved");
  a_sweep_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    sweep_delay |=> !sweep_start)
    else $error("sweep started during delay");
  a_pulse_high: assert property (@(posedge pclk)
    disable iff (!presetn)
    som == sgtp_pkg::SOM_PULSE_HIGH && end_of_sweep
    ##1 som == sgtp_pkg::SOM_PULSE_HIGH |-> seq_out)
    else $error("end sweep pulse missing");
  // limit copy missed its sample while reset was still low
  a_seq_copy: assert property (@(posedge pclk)
    disable iff (!presetn)
    $past(presetn) |-> tset_seq_out == seq_out
    && tset_limit_out == $past(limit_fail))
    else $error("connector copies differ");
  a_call_return: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_en && paddr == sgtp_pkg::ADDR_SEQCMD && !preset_req && por_reg
    && state_reg == sgtp_pkg::SGTP_RUN
    && cmd_op == sgtp_pkg::OP_CALL && dest_ok
    |=> ret_ok_reg && ret_pc_reg == $past(pc_reg) + 8'h01
        && slot_reg == $past(cmd_dest) && pc_reg == 8'h00)
    else $error("call did not save return point");
  a_preset_idle: assert property (@(posedge pclk)
    disable iff (!presetn)
    por_reg && preset_req |=> state_reg == sgtp_pkg::SGTP_IDLE)
    else $error("preset left sequencer running");
endmodule

// *** shared/sgtp_pkg.sv ***
// package: register map, fields, codes and timing for the gpio test-set port
package sgtp_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // mode, direction, selector
  localparam logic [7:0] ADDR_PAROUT  = 8'h04; // parallel output byte
  localparam logic [7:0] ADDR_BITCMD  = 8'h08; // bit set and clear
  localparam logic [7:0] ADDR_FIXTURE = 8'h0c; // fwd and rev fixture codes
  localparam logic [7:0] ADDR_SEQCMD  = 8'h10; // sequencer command
  localparam logic [7:0] ADDR_SEQSTAT = 8'h14; // sequencer state, inputs
  localparam logic [7:0] ADDR_LOOP    = 8'h18; // loop counter
  localparam logic [7:0] ADDR_LOOPDEC = 8'h1c; // loop counter, five digits
  localparam logic [7:0] ADDR_SIZE    = 8'h20; // sequence size accounting
  // control field positions
  localparam int CTRL_GPIO   = 0; // 1 = general purpose, 0 = printer copy
  localparam int CTRL_SOM_LO = 1; // sequencing output mode, two bits
  localparam int CTRL_FWD    = 3; // 1 = forward measurement
  localparam int CTRL_SEL_LO = 4; // input bit selector, three bits
  // bit command fields
  localparam int BIT_SET = 8; // set the indexed bit
  localparam int BIT_CLR = 9; // clear the indexed bit
  // fixture register field
  localparam int FIX_REV_LO = 4; // reverse code low bit
  // sequencer command fields
  localparam int SEQ_DEST_LO = 4; // destination slot low bit
  // size command fields
  localparam int SIZE_CNT_LO = 4;  // digit count low bit
  localparam int SIZE_CLEAR  = 31; // clear the running total
  // sequencing output modes
  localparam logic [1:0] SOM_STATIC_LOW  = 2'h0;
  localparam logic [1:0] SOM_STATIC_HIGH = 2'h1;
  localparam logic [1:0] SOM_PULSE_HIGH  = 2'h2;
  localparam logic [1:0] SOM_PULSE_LOW   = 2'h3;
  // sequencer opcodes
  localparam logic [2:0] OP_NEXT    = 3'h0; // continue with next command
  localparam logic [2:0] OP_JUMP    = 3'h1; // one-way jump
  localparam logic [2:0] OP_JMP_HI  = 3'h2; // jump if selected input high
  localparam logic [2:0] OP_JMP_LO  = 3'h3; // jump if selected input low
  localparam logic [2:0] OP_CALL    = 3'h4; // call and return
  localparam logic [2:0] OP_RETURN  = 3'h5; // end of called sequence
  localparam logic [2:0] OP_STOP    = 3'h6; // halt the sequencer
  // size kinds and charges
  localparam logic [1:0] KIND_TYPICAL = 2'h0;
  localparam logic [1:0] KIND_TITLE   = 2'h1;
  localparam logic [1:0] KIND_ENTRY   = 2'h2;
  localparam logic [11:0] COST_TYPICAL = 12'h002;
  localparam logic [11:0] COST_TITLE   = 12'h001;
  // slots
  localparam logic [2:0] SLOT_FIRST = 3'h1;
  localparam logic [2:0] SLOT_LAST  = 3'h6;
  localparam logic [2:0] SLOT_AUTO  = 3'h6;
  localparam logic [2:0] IN_BITS_MAX = 3'h4; // highest input index
  // end-of-sweep pulse width
  localparam int CLK_NS      = 50;
  localparam int PULSE_NS    = 1000;
  localparam int PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] PULSE_CNT = 5'(PULSE_CYC);
  // sequencer states
  typedef enum logic [1:0] {
    SGTP_IDLE = 2'b01,
    SGTP_RUN  = 2'b10
  } sgtp_state_e;
endpackage

// *** bench/sgtp_fixture_model.sv ***
// external test set model: latches fixture code, drives sweep hold-off
`timescale 1ns/1ps
module sgtp_fixture_model (
  input  wire logic       pclk,
  input  wire logic [2:0] fixture_code,
  input  wire logic       fixture_valid_n,
  input  wire logic       busy,
  output logic            sweep_delay,
  output logic [2:0]      latched
);
  // hold-off stays up while our own sweep runs
  assign sweep_delay = busy;
  // code captured only while the low strobe marks it valid
  always_ff @(posedge pclk)
    if (!fixture_valid_n)
      latched <= fixture_code;
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the gpio test-set port
`timescale 1ns/1ps
module testbench;
  logic        pclk = 1'b0;     // 20 mhz clock
  logic        presetn = 1'b0;  // reset, low active
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        preset_req = 1'b0;
  logic        autostart_titled = 1'b0;
  logic [4:0]  par_in = 5'h00;
  logic        sweep_request = 1'b0;
  logic        end_of_sweep = 1'b0;
  logic        limit_fail = 1'b0;
  logic        busy = 1'b1;     // test set still sweeping
  logic        pready, pslverr, fixture_valid_n, fwd_dir, sweep_start;
  logic        seq_out, tset_seq_out, tset_limit_out, sweep_delay;
  logic [31:0] prdata;
  logic [7:0]  par_out;
  logic [2:0]  fixture_code, latched;
  logic [31:0] q;               // last read data
  logic        err;             // last slave error
  int          num_errors = 0;
  int          n_tests = 0;
  int          n_starts = 0;    // sweep start pulses seen
  sgtp_top dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .preset_req, .autostart_titled,
    .par_in, .par_out, .fixture_code, .fixture_valid_n, .fwd_dir,
    .sweep_delay, .sweep_request, .sweep_start, .end_of_sweep,
    .seq_out, .tset_seq_out, .limit_fail, .tset_limit_out
  );
  sgtp_fixture_model fix_u (
    .pclk, .fixture_code, .fixture_valid_n, .busy, .sweep_delay,
    .latched
  );
  // clock generator
  always #25 pclk = ~pclk;
  // count start pulses
  always @(posedge pclk)
    if (sweep_start === 1'b1)
      n_starts++;
  // verdict and end of run
  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // wait cycles, then settle past the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        num_errors++;
        report_and_stop();
      end
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // byte writes land and hold
  task automatic t_byte();
    chk("par_out", 32'h0, par_out);
    chk("seq_out", 32'h0, seq_out);
    wr(sgtp_pkg::ADDR_PAROUT, 32'ha5);
    chk("par_out", 32'ha5, par_out);
    wr(sgtp_pkg::ADDR_FIXTURE, 32'h0);
    chk("par_out", 32'ha5, par_out);
    wr(sgtp_pkg::ADDR_PAROUT, 32'hff);
    chk("par_out", 32'hff, par_out);
    rd(8'h24);
    chk("unmapped_err", 32'h1, err);
    chk("unmapped_data", 32'h0, q);
  endtask
  // bit commands gated by mode
  task automatic t_bits();
    wr(sgtp_pkg::ADDR_BITCMD, 32'h203);
    chk("par_out", 32'hff, par_out);
    wr(sgtp_pkg::ADDR_CTRL, 32'h1);
    wr(sgtp_pkg::ADDR_BITCMD, 32'h203);
    chk("par_out", 32'hf7, par_out);
    wr(sgtp_pkg::ADDR_PAROUT, 32'h0);
    wr(sgtp_pkg::ADDR_BITCMD, 32'h106);
    chk("par_out", 32'h40, par_out);
  endtask
  // codes follow direction, strobe low when valid
  task automatic t_fix();
    wr(sgtp_pkg::ADDR_FIXTURE, 32'h25);
    wr(sgtp_pkg::ADDR_CTRL, 32'h9);
    cyc(3);
    chk("code", 32'h5, fixture_code);
    chk("fwd_dir", 32'h1, fwd_dir);
    chk("valid_n", 32'h0, fixture_valid_n);
    chk("latched", 32'h5, latched);
    wr(sgtp_pkg::ADDR_CTRL, 32'h1);
    cyc(3);
    chk("code", 32'h2, fixture_code);
    chk("fwd_dir", 32'h0, fwd_dir);
    chk("latched", 32'h2, latched);
  endtask
  // four sequencing output modes and connector copies
  task automatic t_som();
    wr(sgtp_pkg::ADDR_CTRL, 32'h3);
    chk("seq_out", 32'h1, seq_out);
    chk("tset_seq", 32'h1, tset_seq_out);
    wr(sgtp_pkg::ADDR_CTRL, 32'h1);
    chk("seq_out", 32'h0, seq_out);
    for (int m = 2; m < 4; m++)
    begin
      wr(sgtp_pkg::ADDR_CTRL, m * 2 + 1);
      chk("seq_idle", m - 2, seq_out);
      @(posedge pclk);
      end_of_sweep <= 1'b1;
      @(posedge pclk);
      end_of_sweep <= 1'b0;
      cyc(2);
      chk("seq_pulse", 3 - m, seq_out);
      chk("tset_seq", 3 - m, tset_seq_out);
      cyc(25);
      chk("seq_after", m - 2, seq_out);
    end
    @(posedge pclk);
    limit_fail <= 1'b1;
    cyc(2);
    chk("tset_limit", 32'h1, tset_limit_out);
  endtask
  // hold-off delays the requested sweep
  task automatic t_sweep();
    @(posedge pclk);
    sweep_request <= 1'b1;
    @(posedge pclk);
    sweep_request <= 1'b0;
    cyc(10);
    chk("starts", 32'h0, n_starts);
    @(posedge pclk);
    busy <= 1'b0;
    cyc(5);
    chk("starts", 32'h1, n_starts);
  endtask
  // input-tested jumps; selector picks bit two
  task automatic t_jump();
    wr(sgtp_pkg::ADDR_CTRL, 32'h21);
    @(posedge pclk);
    par_in <= 5'h04;
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h32);
    rd(sgtp_pkg::ADDR_SEQSTAT);
    chk("stat", 32'h7, q[3:0]);
    chk("inputs", 32'h4, q[21:17]);
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h06);
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h43);
    rd(sgtp_pkg::ADDR_SEQSTAT);
    chk("stat", 32'h6, q[3:0]);
    @(posedge pclk);
    par_in <= 5'h00;
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h43);
    rd(sgtp_pkg::ADDR_SEQSTAT);
    chk("stat", 32'h9, q[3:0]);
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h06);
  endtask
  // size charges and five-digit loop counter
  task automatic t_size();
    wr(sgtp_pkg::ADDR_SIZE, 32'h80000000);
    wr(sgtp_pkg::ADDR_SIZE, 32'h0);
    wr(sgtp_pkg::ADDR_SIZE, 32'h1);
    wr(sgtp_pkg::ADDR_SIZE, 32'h32);
    rd(sgtp_pkg::ADDR_SIZE);
    chk("size", 32'h6, q);
    wr(sgtp_pkg::ADDR_LOOP, 32'h3039);
    rd(sgtp_pkg::ADDR_LOOPDEC);
    chk("loopdec", 32'h12345, q);
  endtask
  // second power-up autostarts slot six; preset returns it to idle
  task automatic t_auto();
    @(posedge pclk);
    presetn <= 1'b0;
    autostart_titled <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    chk("par_out", 32'h0, par_out);
    rd(sgtp_pkg::ADDR_SEQSTAT);
    chk("auto", 32'hd, q[3:0]);
    @(posedge pclk);
    preset_req <= 1'b1;
    @(posedge pclk);
    preset_req <= 1'b0;
    cyc(3);
    rd(sgtp_pkg::ADDR_SEQSTAT);
    chk("preset", 32'hc, q[3:0]);
  endtask
  // call by slot position, return resumes after the call
  task automatic t_call();
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h24);
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h0);
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h0);
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h54);
    rd(sgtp_pkg::ADDR_SEQSTAT);
    chk("call", 32'h5b, q[16:0]);
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h05);
    rd(sgtp_pkg::ADDR_SEQSTAT);
    chk("return", 32'h645, q[16:0]);
    wr(sgtp_pkg::ADDR_SEQCMD, 32'h05);
    rd(sgtp_pkg::ADDR_SEQSTAT);
    chk("ret_end", 32'h644, q[16:0]);
  endtask
  // hang guard
  initial
  begin
    #2000000;
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(2);
    t_byte();
    t_bits();
    t_fix();
    t_som();
    t_sweep();
    t_jump();
    t_size();
    t_auto();
    t_call();
    report_and_stop();
  end
endmodule
